// ==== hdl/rlr_regs_map.svh ====
`ifndef RLR_REGS_MAP_SVH
`define RLR_REGS_MAP_SVH

// Byte addresses on the internal system bus
`define RLR_OFF_PKT_LEN_SEL      24'h0ef180
`define RLR_OFF_WHITEN_CHAN_SEL  24'h0ef181
`define RLR_OFF_FIXED_FREQ_SEL   24'h0ef182
`define RLR_OFF_NATIVE_CLK_B0    24'h0ef198
`define RLR_OFF_NATIVE_CLK_B1    24'h0ef199
`define RLR_OFF_NATIVE_CLK_B2    24'h0ef19a
`define RLR_OFF_NATIVE_CLK_B3    24'h0ef19b
`define RLR_OFF_RX_CHAN_NUMBER   24'h0ef19c
`define RLR_OFF_TX_CHAN_NUMBER   24'h0ef19d
`define RLR_OFF_AC_ACCEPT_LEVEL  24'h0ef19e
`define RLR_OFF_LAP_ACCEPT_LEVEL 24'h0ef1a0
`define RLR_OFF_RF_SYNC_DELAY    24'h0ef1a1
`define RLR_OFF_SERIAL_READBACK  24'h0ef1a2
`define RLR_OFF_SERIAL_MODE_CFG  24'h0ef1a4
`define RLR_OFF_SLOT_M_B0        24'h0ef1a6
`define RLR_OFF_SLOT_M_B1        24'h0ef1a7
`define RLR_OFF_SLOT_M_B2        24'h0ef1a8
`define RLR_OFF_SLOT_N_B0        24'h0ef1aa
`define RLR_OFF_SLOT_N_B1        24'h0ef1ab
`define RLR_OFF_CLK_LOAD_B0      24'h0ef1ac
`define RLR_OFF_CLK_LOAD_B1      24'h0ef1ad
`define RLR_OFF_CLK_LOAD_B2      24'h0ef1ae
`define RLR_OFF_CLK_LOAD_B3      24'h0ef1af
`define RLR_OFF_WAIT_ONE_SLOT    24'h0ef1b0
`define RLR_OFF_WAIT_THREE_SLOT  24'h0ef1b2
`define RLR_OFF_WAIT_FIVE_SLOT   24'h0ef1b4
`define RLR_OFF_SEQUENCER_RESET_STROBE        24'h0ef1b6
`define RLR_OFF_SEQ_RESUME       24'h0ef1b7
`define RLR_OFF_RX_STATE_FLAGS   24'h0ef1b8
`define RLR_OFF_PART_IDENT       24'h0ef1ba
`define RLR_OFF_IRQ_VECTOR       24'h0ef1bc
`define RLR_OFF_SYS_CLOCK_GATE   24'h0ef1be
`define RLR_OFF_LINK_TIMER_DATA  24'h0ef1c0
`define RLR_OFF_LINK_TIMER_SEL   24'h0ef1c2
`define RLR_OFF_LINK_TIMER_EXP   24'h0ef1c4
`define RLR_OFF_LINK_TIMER_RWF   24'h0ef1c5
`define RLR_OFF_LINK_TIMER_UP    24'h0ef1c6
`define RLR_OFF_LINK_TIMER_DOWN  24'h0ef1c7
`define RLR_OFF_SLOT_TIMER_DATA  24'h0ef1c8

// Field positions and reset values
`define RLR_BYTE_MSB             7
`define RLR_WORD_MSB             15
`define RLR_RESET_BYTE           8'h00
`define RLR_RESET_WORD           16'h0000

`endif

// ==== hdl/rlr_pkg.sv ====
// Purpose: types shared by the radio link register bank
// Assumes: constants come from rlr_regs_map.svh
// Notes:   the whole bank state is one packed struct
package rlr_pkg;
    typedef logic [7:0]  rlr_byte_t;
    typedef logic [15:0] rlr_word_t;
    typedef logic [23:0] rlr_addr_t;

    typedef struct packed {
        rlr_byte_t           pktLenSel;
        rlr_byte_t           whitenChanSel;
        rlr_byte_t           fixedFreqSel;
        rlr_word_t           acAcceptLevel;
        rlr_byte_t           lapAcceptLevel;
        rlr_byte_t           rfSyncDelay;
        rlr_byte_t           serialModeCfg;
        rlr_byte_t [2:0]     slotMCount;
        rlr_byte_t [1:0]     slotNCount;
        rlr_byte_t [3:0]     clockLoad;
        logic      [3:0]     clockLoadStrobe;
        rlr_word_t           waitOneSlot;
        rlr_word_t           waitThreeSlot;
        rlr_word_t           waitFiveSlot;
        rlr_byte_t           sysClockGate;
        logic                seqResetStrobe;
        logic                seqResumeStrobe;
        rlr_word_t           rdData;
        logic                rdValid;
    } rlr_state_t;
endpackage : rlr_pkg

// ==== hdl/rlr_radio_llc_regs.sv ====
// Purpose: register decode and storage for the radio link controller bank
// Assumes: one bus access per cycle; byte data on busWrData[7:0]
// Notes:   reads answer one cycle after the strobe; refused reads return zero
//
// Behaviour
// - A byte register has one address and answers only byte accesses.
// - A word register spans two addresses and answers only word accesses.
// - Word registers sit at even addresses; word accesses need an even address.
// - Byte registers use only the low eight data lines.
// - Reserved bits may read as anything.
// - Four native clock bytes are read-only, one byte of running clock each.
// - Sequencer reset and resume are write-only bytes acting as commands.
// - Slot M bytes are read/write; slot N bytes are write-only.
// - Four clock load bytes are write-only, one byte per address.
`include "rlr_regs_map.svh"

module rlr_radio_llc_regs #(
    parameter logic [7:0] PART_IDENT = 8'h5a   // Arbitrary value
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire rlr_pkg::rlr_addr_t busAddr,
    input  wire logic              busRd,
    input  wire logic              busWr,
    input  wire logic              busWord,
    input  wire rlr_pkg::rlr_word_t busWrData,
    output      rlr_pkg::rlr_word_t busRdData,
    output      logic              busRdValid,
    input  wire logic [31:0]       nativeClock,
    input  wire rlr_pkg::rlr_byte_t rxChanNumber,
    input  wire rlr_pkg::rlr_byte_t txChanNumber,
    input  wire rlr_pkg::rlr_word_t radioSerialReadback,
    input  wire rlr_pkg::rlr_byte_t receiveStateFlags,
    input  wire rlr_pkg::rlr_byte_t irqVector,
    input  wire rlr_pkg::rlr_word_t linkTimerData,
    input  wire rlr_pkg::rlr_byte_t linkTimerSel,
    input  wire rlr_pkg::rlr_byte_t linkTimerExpired,
    input  wire rlr_pkg::rlr_byte_t linkTimerRwFlag,
    input  wire rlr_pkg::rlr_byte_t linkTimerAdjUp,
    input  wire rlr_pkg::rlr_byte_t linkTimerAdjDown,
    input  wire rlr_pkg::rlr_byte_t slotTimerData,
    output      rlr_pkg::rlr_byte_t packetLengthSel,
    output      rlr_pkg::rlr_byte_t whitenChanSel,
    output      rlr_pkg::rlr_byte_t fixedFreqSel,
    output      rlr_pkg::rlr_word_t accessCodeAcceptLevel,
    output      rlr_pkg::rlr_byte_t lowerAddrAcceptLevel,
    output      rlr_pkg::rlr_byte_t rfSyncDelay,
    output      rlr_pkg::rlr_byte_t radioSerialModeCfg,
    output      logic [23:0]       slotMCount,
    output      logic [15:0]       slotNCount,
    output      logic [31:0]       clockLoadValue,
    output      logic [3:0]        clockLoadStrobe,
    output      rlr_pkg::rlr_word_t waitCountOneSlot,
    output      rlr_pkg::rlr_word_t waitCountThreeSlot,
    output      rlr_pkg::rlr_word_t waitCountFiveSlot,
    output      rlr_pkg::rlr_byte_t sysClockGate,
    output      logic              sequencerResetStrobe,
    output      logic              sequencerResumeStrobe
);
    import rlr_pkg::*;

    rlr_state_t cur;
    rlr_state_t next_cur;

    function automatic logic isWordReg(input rlr_addr_t a);
        isWordReg = (a == `RLR_OFF_AC_ACCEPT_LEVEL) || (a == `RLR_OFF_SERIAL_READBACK)
                 || (a == `RLR_OFF_WAIT_ONE_SLOT)    || (a == `RLR_OFF_WAIT_THREE_SLOT)
                 || (a == `RLR_OFF_WAIT_FIVE_SLOT)   || (a == `RLR_OFF_LINK_TIMER_DATA);
    endfunction : isWordReg

    // Size and alignment gate shared by the write and read paths
    function automatic logic sizeLegal(input rlr_addr_t a, input logic word);
        if (word) begin
            sizeLegal = isWordReg(a) && !a[0];
        end else begin
            sizeLegal = !isWordReg(a);
        end
    endfunction : sizeLegal

    function automatic rlr_word_t zxByte(input rlr_byte_t b);
        zxByte = {8'h00, b};
    endfunction : zxByte

    logic wrOk;
    logic rdOk;
    assign wrOk = busWr && sizeLegal(busAddr, busWord);
    assign rdOk = busRd && sizeLegal(busAddr, busWord);

    always_comb begin
        next_cur                 = cur;
        next_cur.clockLoadStrobe = 4'h0;
        next_cur.seqResetStrobe  = 1'b0;
        next_cur.seqResumeStrobe = 1'b0;
        next_cur.rdValid         = busRd;
        // Refused or unmapped reads answer zero so the bus never sees stale data
        next_cur.rdData          = `RLR_RESET_WORD;
        if (wrOk) begin
            unique case (busAddr)
                `RLR_OFF_PKT_LEN_SEL:      next_cur.pktLenSel      = busWrData[`RLR_BYTE_MSB:0];
                `RLR_OFF_WHITEN_CHAN_SEL:  next_cur.whitenChanSel  = busWrData[`RLR_BYTE_MSB:0];
                `RLR_OFF_FIXED_FREQ_SEL:   next_cur.fixedFreqSel   = busWrData[`RLR_BYTE_MSB:0];
                `RLR_OFF_AC_ACCEPT_LEVEL:  next_cur.acAcceptLevel  = busWrData;
                `RLR_OFF_LAP_ACCEPT_LEVEL: next_cur.lapAcceptLevel = busWrData[`RLR_BYTE_MSB:0];
                `RLR_OFF_RF_SYNC_DELAY:    next_cur.rfSyncDelay    = busWrData[`RLR_BYTE_MSB:0];
                `RLR_OFF_SERIAL_MODE_CFG:  next_cur.serialModeCfg  = busWrData[`RLR_BYTE_MSB:0];
                `RLR_OFF_SLOT_M_B0:        next_cur.slotMCount[0]  = busWrData[7:0];
                `RLR_OFF_SLOT_M_B1:        next_cur.slotMCount[1]  = busWrData[7:0];
                `RLR_OFF_SLOT_M_B2:        next_cur.slotMCount[2]  = busWrData[7:0];
                `RLR_OFF_SLOT_N_B0:        next_cur.slotNCount[0]  = busWrData[7:0];
                `RLR_OFF_SLOT_N_B1:        next_cur.slotNCount[1]  = busWrData[7:0];
                `RLR_OFF_CLK_LOAD_B0: begin
                    next_cur.clockLoad[0]       = busWrData[7:0];
                    next_cur.clockLoadStrobe[0] = 1'b1;
                end
                `RLR_OFF_CLK_LOAD_B1: begin
                    next_cur.clockLoad[1]       = busWrData[7:0];
                    next_cur.clockLoadStrobe[1] = 1'b1;
                end
                `RLR_OFF_CLK_LOAD_B2: begin
                    next_cur.clockLoad[2]       = busWrData[7:0];
                    next_cur.clockLoadStrobe[2] = 1'b1;
                end
                `RLR_OFF_CLK_LOAD_B3: begin
                    next_cur.clockLoad[3]       = busWrData[7:0];
                    next_cur.clockLoadStrobe[3] = 1'b1;
                end
                `RLR_OFF_WAIT_ONE_SLOT:    next_cur.waitOneSlot    = busWrData;
                `RLR_OFF_WAIT_THREE_SLOT:  next_cur.waitThreeSlot  = busWrData;
                `RLR_OFF_WAIT_FIVE_SLOT:   next_cur.waitFiveSlot   = busWrData;
                `RLR_OFF_SEQUENCER_RESET_STROBE:        next_cur.seqResetStrobe  = 1'b1;
                `RLR_OFF_SEQ_RESUME:       next_cur.seqResumeStrobe = 1'b1;
                `RLR_OFF_SYS_CLOCK_GATE:   next_cur.sysClockGate   = busWrData[`RLR_BYTE_MSB:0];
                // Read-only and unmapped addresses drop the write
                default: ;
            endcase
        end
        // Bits a register does not drive read as zero, though callers may not rely on it
        if (rdOk) begin
            unique case (busAddr)
                `RLR_OFF_NATIVE_CLK_B0:   next_cur.rdData = zxByte(nativeClock[7:0]);
                `RLR_OFF_NATIVE_CLK_B1:   next_cur.rdData = zxByte(nativeClock[15:8]);
                `RLR_OFF_NATIVE_CLK_B2:   next_cur.rdData = zxByte(nativeClock[23:16]);
                `RLR_OFF_NATIVE_CLK_B3:   next_cur.rdData = zxByte(nativeClock[31:24]);
                `RLR_OFF_RX_CHAN_NUMBER:  next_cur.rdData = zxByte(rxChanNumber);
                `RLR_OFF_TX_CHAN_NUMBER:  next_cur.rdData = zxByte(txChanNumber);
                `RLR_OFF_SERIAL_READBACK: next_cur.rdData = radioSerialReadback;
                `RLR_OFF_SLOT_M_B0:       next_cur.rdData = zxByte(cur.slotMCount[0]);
                `RLR_OFF_SLOT_M_B1:       next_cur.rdData = zxByte(cur.slotMCount[1]);
                `RLR_OFF_SLOT_M_B2:       next_cur.rdData = zxByte(cur.slotMCount[2]);
                `RLR_OFF_RX_STATE_FLAGS:  next_cur.rdData = zxByte(receiveStateFlags);
                `RLR_OFF_PART_IDENT:      next_cur.rdData = zxByte(PART_IDENT);
                `RLR_OFF_IRQ_VECTOR:      next_cur.rdData = zxByte(irqVector);
                `RLR_OFF_LINK_TIMER_DATA: next_cur.rdData = linkTimerData;
                `RLR_OFF_LINK_TIMER_SEL:  next_cur.rdData = zxByte(linkTimerSel);
                `RLR_OFF_LINK_TIMER_EXP:  next_cur.rdData = zxByte(linkTimerExpired);
                `RLR_OFF_LINK_TIMER_RWF:  next_cur.rdData = zxByte(linkTimerRwFlag);
                `RLR_OFF_LINK_TIMER_UP:   next_cur.rdData = zxByte(linkTimerAdjUp);
                `RLR_OFF_LINK_TIMER_DOWN: next_cur.rdData = zxByte(linkTimerAdjDown);
                `RLR_OFF_SLOT_TIMER_DATA: next_cur.rdData = zxByte(slotTimerData);
                // Write-only and unmapped addresses keep the zero answer
                default: ;
            endcase
        end
    end

    // Reset wins over the clock enable so a frozen bank still comes up clean
    always_ff @(posedge clk) begin
        if (srst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign busRdData             = cur.rdData;
    assign busRdValid            = cur.rdValid;
    assign packetLengthSel       = cur.pktLenSel;
    assign whitenChanSel         = cur.whitenChanSel;
    assign fixedFreqSel          = cur.fixedFreqSel;
    assign accessCodeAcceptLevel = cur.acAcceptLevel;
    assign lowerAddrAcceptLevel  = cur.lapAcceptLevel;
    assign rfSyncDelay           = cur.rfSyncDelay;
    assign radioSerialModeCfg    = cur.serialModeCfg;
    assign slotMCount            = cur.slotMCount;
    assign slotNCount            = cur.slotNCount;
    assign clockLoadValue        = cur.clockLoad;
    assign clockLoadStrobe       = cur.clockLoadStrobe;
    assign waitCountOneSlot      = cur.waitOneSlot;
    assign waitCountThreeSlot    = cur.waitThreeSlot;
    assign waitCountFiveSlot     = cur.waitFiveSlot;
    assign sysClockGate          = cur.sysClockGate;
    assign sequencerResetStrobe  = cur.seqResetStrobe;
    assign sequencerResumeStrobe = cur.seqResumeStrobe;

    AST_BYTE_WRITE_ONLY_BYTE: assert property (@(posedge clk) disable iff (srst)
        (ce && busWr && busWord && busAddr == `RLR_OFF_PKT_LEN_SEL)
        |=> $stable(packetLengthSel))
        else $error("byte register changed on a word write");

    AST_WORD_TAKES_WORD: assert property (@(posedge clk) disable iff (srst)
        (ce && busWr && busWord && busAddr == `RLR_OFF_AC_ACCEPT_LEVEL)
        |=> accessCodeAcceptLevel == $past(busWrData))
        else $error("word write not stored in full");

    AST_WORD_REFUSES_BYTE: assert property (@(posedge clk) disable iff (srst)
        (ce && busWr && !busWord && (busAddr == `RLR_OFF_WAIT_ONE_SLOT
            || busAddr == `RLR_OFF_WAIT_ONE_SLOT + 24'h000001))
        |=> $stable(waitCountOneSlot))
        else $error("word register changed on a byte write");

    AST_ODD_WORD_REFUSED: assert property (@(posedge clk) disable iff (srst)
        (ce && busRd && busWord && busAddr[0]) |=> busRdValid && busRdData == 16'h0000)
        else $error("odd word read was answered with data");

    AST_BYTE_LOW_LANE: assert property (@(posedge clk) disable iff (srst)
        (ce && busRd && !busWord) |=> busRdValid && busRdData[15:8] == 8'h00)
        else $error("byte read drove the upper lanes");

    AST_NATIVE_CLOCK_READ: assert property (@(posedge clk) disable iff (srst)
        (ce && busRd && !busWord && busAddr == `RLR_OFF_NATIVE_CLK_B2)
        |=> busRdData[7:0] == $past(nativeClock[23:16]))
        else $error("native clock byte read wrong");

    AST_SEQUENCER_RESET_STROBE_PULSE: assert property (@(posedge clk) disable iff (srst)
        (ce && busWr && !busWord && busAddr == `RLR_OFF_SEQUENCER_RESET_STROBE)
        |=> sequencerResetStrobe && !sequencerResumeStrobe)
        else $error("sequencer reset command not issued");

    AST_SLOT_M_READBACK: assert property (@(posedge clk) disable iff (srst)
        (ce && busWr && !busWord && busAddr == `RLR_OFF_SLOT_M_B1)
        ##1 (ce && busRd && !busWord && busAddr == `RLR_OFF_SLOT_M_B1)
        |=> busRdData == {8'h00, $past(busWrData[7:0], 2)})
        else $error("slot M byte did not read back");

    AST_SLOT_N_WRITE_ONLY: assert property (@(posedge clk) disable iff (srst)
        (ce && busRd && busAddr == `RLR_OFF_SLOT_N_B0) |=> busRdData == 16'h0000)
        else $error("slot N byte answered a read");

    AST_CLOCK_LOAD_BYTE: assert property (@(posedge clk) disable iff (srst)
        (ce && busWr && !busWord && busAddr == `RLR_OFF_CLK_LOAD_B3)
        |=> clockLoadStrobe == 4'h8 && clockLoadValue[31:24] == $past(busWrData[7:0]))
        else $error("clock load byte not taken");

    AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> (slotMCount == 24'h000000 && clockLoadValue == 32'h00000000
            && waitCountFiveSlot == 16'h0000 && !busRdValid && !sequencerResetStrobe))
        else $error("storage not cleared by reset");

endmodule : rlr_radio_llc_regs

// ==== bench/rlr_bus_master.sv ====
// Purpose: processor-side bus master that issues one byte or word access per call
// Assumes: called just after a rising edge; the request is held for one taken edge
// Notes:   released address and write data lines show inverted values so stale data never looks valid
module rlr_bus_master (
    input  wire logic               clk,
    input  wire rlr_pkg::rlr_word_t busRdData,
    input  wire logic               busRdValid,
    output rlr_pkg::rlr_addr_t      busAddr,
    output logic                    busRd,
    output logic                    busWr,
    output logic                    busWord,
    output rlr_pkg::rlr_word_t      busWrData
);
    timeunit 1ns;
    timeprecision 100ps;
    import rlr_pkg::*;

    initial begin
        busAddr   = 24'h000000;
        busRd     = 1'h0;
        busWr     = 1'h0;
        busWord   = 1'h0;
        busWrData = 16'h0000;
    end

    // Only the bench chooses unmapped or wrong-direction accesses
    task automatic access(input logic rd, input rlr_addr_t a, input logic w, input int gap,
                          input rlr_word_t d, output rlr_word_t q, output logic v);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #1;
        busAddr   = a;
        busWord   = w;
        busWrData = d; // Callers may pass nonzero reserved bits; byte registers ignore them
        busRd     = rd;
        busWr     = !rd;
        @(posedge clk);
        #1;
        q         = busRdData;
        v         = busRdValid;
        busRd     = 1'h0;
        busWr     = 1'h0;
        busAddr   = ~a;
        busWrData = ~d;
    endtask : access
endmodule : rlr_bus_master

// ==== bench/test_radio_llc_register_decode.sv ====
// Purpose: self-checking bench for the radio link register bank
// Assumes: refused reads answer zero with a valid pulse
// Notes:   status inputs hold distinct patterns so a wrong lane shows
module test_radio_llc_register_decode;
    timeunit 1ns;
    timeprecision 100ps;
    import rlr_pkg::*;
    typedef struct {logic rd; logic [7:0] a; logic w; rlr_word_t d; int s; logic [31:0] e;} rlr_row_t;
    localparam rlr_addr_t B = 24'h0ef100;
    logic        clk, srst, ce, busRd, busWr, busWord, busRdValid, v;
    rlr_addr_t   busAddr;
    rlr_word_t   busWrData, busRdData, q;
    logic [31:0] nativeClock = 32'h8c4d2e17;
    rlr_byte_t   rxChanNumber = 8'h3a, txChanNumber = 8'hc5, receiveStateFlags = 8'h69;
    rlr_byte_t   irqVector = 8'h96, linkTimerSel = 8'h21, linkTimerExpired = 8'h42;
    rlr_byte_t   linkTimerRwFlag = 8'h84, linkTimerAdjUp = 8'h18, linkTimerAdjDown = 8'h81;
    rlr_byte_t   slotTimerData = 8'h5c;
    rlr_word_t   radioSerialReadback = 16'hb2e4, linkTimerData = 16'h7e1d;
    rlr_byte_t   packetLengthSel, whitenChanSel, fixedFreqSel, lowerAddrAcceptLevel;
    rlr_byte_t   rfSyncDelay, radioSerialModeCfg, sysClockGate;
    rlr_word_t   accessCodeAcceptLevel, waitCountOneSlot, waitCountThreeSlot, waitCountFiveSlot;
    logic [23:0] slotMCount;
    logic [15:0] slotNCount;
    logic [31:0] clockLoadValue;
    logic [3:0]  clockLoadStrobe;
    logic        sequencerResetStrobe, sequencerResumeStrobe;
    int          failures = 0, n_tests = 0, cyc = 0;

    rlr_radio_llc_regs #(.PART_IDENT(8'h33)) uut (.clk, .srst, .ce, .busAddr, .busRd, .busWr,
        .busWord, .busWrData, .busRdData, .busRdValid, .nativeClock, .rxChanNumber,
        .txChanNumber, .radioSerialReadback, .receiveStateFlags, .irqVector, .linkTimerData,
        .linkTimerSel, .linkTimerExpired, .linkTimerRwFlag, .linkTimerAdjUp, .linkTimerAdjDown,
        .slotTimerData, .packetLengthSel, .whitenChanSel, .fixedFreqSel, .accessCodeAcceptLevel,
        .lowerAddrAcceptLevel, .rfSyncDelay, .radioSerialModeCfg, .slotMCount, .slotNCount,
        .clockLoadValue, .clockLoadStrobe, .waitCountOneSlot, .waitCountThreeSlot,
        .waitCountFiveSlot, .sysClockGate, .sequencerResetStrobe, .sequencerResumeStrobe);
    rlr_bus_master uBus (.clk, .busRdData, .busRdValid, .busAddr, .busRd, .busWr, .busWord,
        .busWrData);

    // Reads expect e on busRdData; writes expect e on output selected by s
    rlr_row_t rows [] = '{
        '{1'h1, 8'h98, 1'h0, 16'h0, 0, 32'h17}, '{1'h1, 8'h99, 1'h0, 16'h0, 0, 32'h2e},
        '{1'h1, 8'h9a, 1'h0, 16'h0, 0, 32'h4d}, '{1'h1, 8'h9b, 1'h0, 16'h0, 0, 32'h8c},
        '{1'h1, 8'h9c, 1'h0, 16'h0, 0, 32'h3a}, '{1'h1, 8'h9d, 1'h0, 16'h0, 0, 32'hc5},
        '{1'h1, 8'ha2, 1'h1, 16'h0, 0, 32'hb2e4}, '{1'h1, 8'hb8, 1'h0, 16'h0, 0, 32'h69},
        '{1'h1, 8'hba, 1'h0, 16'h0, 0, 32'h33}, '{1'h1, 8'hbc, 1'h0, 16'h0, 0, 32'h96},
        '{1'h1, 8'hc0, 1'h1, 16'h0, 0, 32'h7e1d}, '{1'h1, 8'hc2, 1'h0, 16'h0, 0, 32'h21},
        '{1'h1, 8'hc4, 1'h0, 16'h0, 0, 32'h42}, '{1'h1, 8'hc5, 1'h0, 16'h0, 0, 32'h84},
        '{1'h1, 8'hc6, 1'h0, 16'h0, 0, 32'h18}, '{1'h1, 8'hc7, 1'h0, 16'h0, 0, 32'h81},
        '{1'h1, 8'hc8, 1'h0, 16'h0, 0, 32'h5c}, '{1'h1, 8'ha2, 1'h0, 16'h0, 0, 32'h0},
        '{1'h1, 8'ha3, 1'h0, 16'h0, 0, 32'h0}, '{1'h1, 8'h98, 1'h1, 16'h0, 0, 32'h0},
        '{1'h1, 8'hc0, 1'h0, 16'h0, 0, 32'h0}, '{1'h1, 8'h80, 1'h0, 16'h0, 0, 32'h0},
        '{1'h1, 8'h90, 1'h0, 16'h0, 0, 32'h0}, '{1'h1, 8'h9e, 1'h1, 16'h0, 0, 32'h0},
        '{1'h0, 8'h80, 1'h0, 16'h00a5, 0, 32'ha5}, '{1'h0, 8'h81, 1'h1, 16'h1234, 1, 32'h0},
        '{1'h0, 8'h81, 1'h0, 16'h003c, 1, 32'h3c}, '{1'h0, 8'h82, 1'h0, 16'hff77, 2, 32'h77},
        '{1'h0, 8'h9e, 1'h1, 16'hbeef, 3, 32'hbeef}, '{1'h0, 8'h9f, 1'h0, 16'h11, 3, 32'hbeef},
        '{1'h0, 8'h9e, 1'h0, 16'h22, 3, 32'hbeef}, '{1'h0, 8'ha0, 1'h0, 16'h44, 4, 32'h44},
        '{1'h0, 8'ha1, 1'h0, 16'h55, 5, 32'h55}, '{1'h0, 8'ha4, 1'h0, 16'h66, 6, 32'h66},
        '{1'h0, 8'ha6, 1'h0, 16'he1, 7, 32'he1}, '{1'h0, 8'ha7, 1'h0, 16'he2, 7, 32'he2e1},
        '{1'h0, 8'ha8, 1'h0, 16'he3, 7, 32'he3e2e1}, '{1'h1, 8'ha6, 1'h0, 16'h0, 0, 32'he1},
        '{1'h1, 8'ha8, 1'h0, 16'h0, 0, 32'he3}, '{1'h0, 8'ha6, 1'h1, 16'h1111, 7, 32'he3e2e1},
        '{1'h0, 8'haa, 1'h0, 16'h71, 8, 32'h71}, '{1'h0, 8'hab, 1'h0, 16'h72, 8, 32'h7271},
        '{1'h1, 8'haa, 1'h0, 16'h0, 0, 32'h0}, '{1'h0, 8'hb0, 1'h1, 16'h0a0b, 10, 32'h0a0b},
        '{1'h0, 8'hb1, 1'h1, 16'h7777, 10, 32'h0a0b}, '{1'h0, 8'hb2, 1'h1, 16'h0c0d, 11, 32'hc0d},
        '{1'h0, 8'hb4, 1'h1, 16'h0e0f, 12, 32'he0f}, '{1'h0, 8'hb5, 1'h0, 16'h99, 12, 32'he0f},
        '{1'h0, 8'hbe, 1'h0, 16'h88, 13, 32'h88}, '{1'h1, 8'hb0, 1'h1, 16'h0, 0, 32'h0}};

    function automatic logic [31:0] obs(input int s);
        case (s)
            0:       obs = 32'(packetLengthSel);
            1:       obs = 32'(whitenChanSel);
            2:       obs = 32'(fixedFreqSel);
            3:       obs = 32'(accessCodeAcceptLevel);
            4:       obs = 32'(lowerAddrAcceptLevel);
            5:       obs = 32'(rfSyncDelay);
            6:       obs = 32'(radioSerialModeCfg);
            7:       obs = 32'(slotMCount);
            8:       obs = 32'(slotNCount);
            9:       obs = clockLoadValue;
            10:      obs = 32'(waitCountOneSlot);
            11:      obs = 32'(waitCountThreeSlot);
            12:      obs = 32'(waitCountFiveSlot);
            13:      obs = 32'(sysClockGate);
            default: obs = {clockLoadStrobe, sequencerResetStrobe, sequencerResumeStrobe};
        endcase
    endfunction : obs

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkv

    task automatic tally_and_finish();
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // Whole run needs under two hundred cycles; the ceiling at 2000 ends a run that hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        srst = 1'h1;
        ce   = 1'h1;
        repeat (8) @(posedge clk);
        #1 srst = 1'h0;
        for (int s = 0; s <= 14; s++) chkv(obs(s), 32'h0);
        foreach (rows[i]) begin
            uBus.access(rows[i].rd, B | 24'(rows[i].a), rows[i].w, i % 3, rows[i].d, q, v);
            if (rows[i].rd) chkv({v, 15'h0, q}, {1'h1, 15'h0, rows[i].e[15:0]});
            else chkv(obs(rows[i].s), rows[i].e);
        end
        nativeClock = 32'h01020304;
        uBus.access(1'h1, B | 24'h9b, 1'h0, 0, 16'h0, q, v);
        chkv(32'(q), 32'h01);
        for (int i = 0; i < 4; i++) begin
            uBus.access(1'h0, B | 24'(8'hac + i), 1'h0, 0, 16'(8'h10 + i), q, v);
            chkv(32'(clockLoadStrobe), 32'(4'h1 << i));
        end
        chkv(clockLoadValue, 32'h13121110);
        uBus.access(1'h0, B | 24'hb6, 1'h0, 0, 16'h1, q, v);
        chkv(obs(14), 32'h2);
        @(posedge clk);
        #1 chkv(obs(14), 32'h0);
        uBus.access(1'h0, B | 24'hb7, 1'h0, 0, 16'h1, q, v);
        chkv(obs(14), 32'h1);
        uBus.access(1'h0, B | 24'hb6, 1'h1, 0, 16'h1, q, v);
        chkv(obs(14), 32'h0);
        ce = 1'h0;
        uBus.access(1'h0, B | 24'h80, 1'h0, 0, 16'h0f, q, v);
        ce = 1'h1;
        chkv(obs(0), 32'ha5);
        srst = 1'h1;
        @(posedge clk);
        #1 srst = 1'h0;
        for (int s = 0; s <= 14; s++) chkv(obs(s), 32'h0);
        tally_and_finish();
    end
endmodule : test_radio_llc_register_decode
